/* File: core/smsp_defines.vh */
`ifndef SMSP_DEFINES_VH
`define SMSP_DEFINES_VH

// Register indices; the byte address of each register is four times its index.
`define SMSP_IDX_CTRL      10'h0D2
`define SMSP_IDX_DATA      10'h0D3
`define SMSP_IDX_STAT      10'h0D4
`define SMSP_IDX_AUX       10'h0D5

// Field positions of the serial control register.
`define SMSP_CR_EN         7
`define SMSP_CR_LSB        6
`define SMSP_CR_MS         5
`define SMSP_CR_CLOCK_IDLE_LEVEL       4
`define SMSP_CR_CLOCK_SAMPLE_PHASE       3
`define SMSP_CR_DBL        2
`define SMSP_CR_RATE_HI    1
`define SMSP_CR_RATE_LO    0

// Field positions of the serial status register.
`define SMSP_SR_DONE       7
`define SMSP_SR_WRITE_COLLISION_FLAG       6
`define SMSP_SR_SSRISE     5
`define SMSP_SR_TWOPIN     3
`define SMSP_SR_SELECT_PIN_ENABLE      2
`define SMSP_SR_TRANSMIT_ENABLE      1
`define SMSP_SR_RECEIVE_ENABLE      0
`define SMSP_SR_WMASK      8'h0F

// Field positions of the auxiliary register.
`define SMSP_AX_IE         0
`define SMSP_AX_SSDIR      1
`define SMSP_AX_SSOUT      2
`define SMSP_AX_WMASK      8'h07

// Reset values.
`define SMSP_RST_BYTE      8'h00

// Bit and edge counts of one exchange.
`define SMSP_LAST_BIT      4'h7
`define SMSP_LAST_EDGE     5'h0F

// Half periods of SCK in system clocks, indexed by {double, rate}.
`define SMSP_HALF_4        7'h02
`define SMSP_HALF_16       7'h08
`define SMSP_HALF_64       7'h20
`define SMSP_HALF_128      7'h40
`define SMSP_HALF_2        7'h01
`define SMSP_HALF_8        7'h04
`define SMSP_HALF_32       7'h10

`endif

/* File: core/smsp_core.v */
`timescale 1ns/1ns
`include "smsp_defines.vh"

module smsp_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        irq_ack,
  output reg         irq,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe_n,
  input  wire        mosi_i,
  output reg         mosi_o,
  output reg         mosi_oe_n,
  input  wire        miso_i,
  output reg         miso_o,
  output reg         miso_oe_n,
  input  wire        ss_n_i,
  output reg         ss_n_o,
  output reg         ss_n_oe_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Tells whether the bus address hits a given register index.
  function hit;
    input [11:0] addr;
    input [9:0]  idx;
    begin
      hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Gives the SCK half period in system clocks for the rate fields.
  function [6:0] half_period;
    input       dbl;
    input [1:0] rate;
    begin
      case ({dbl, rate})
        3'b000:  half_period = `SMSP_HALF_4;
        3'b001:  half_period = `SMSP_HALF_16;
        3'b010:  half_period = `SMSP_HALF_64;
        3'b011:  half_period = `SMSP_HALF_128;
        3'b100:  half_period = `SMSP_HALF_2;
        3'b101:  half_period = `SMSP_HALF_8;
        3'b110:  half_period = `SMSP_HALF_32;
        default: half_period = `SMSP_HALF_64;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  reg  [7:0] ctrl_q;
  reg  [7:0] stat_q;
  reg  [7:0] aux_q;
  reg  [7:0] tx_q;
  reg  [7:0] rx_q;
  reg  [7:0] rxbuf_q;
  reg        arm_q;
  reg        run_q;
  reg        sck_q;
  reg  [3:0] bit_cnt_q;
  reg  [4:0] edge_cnt_q;
  reg  [6:0] div_cnt_q;
  reg        sck_s1_q;
  reg        sck_s2_q;
  reg        sck_s3_q;
  reg        mosi_s1_q;
  reg        mosi_s2_q;
  reg        miso_s1_q;
  reg        miso_s2_q;
  reg        ss_s1_q;
  reg        ss_s2_q;
  reg        ss_s3_q;
  reg  [7:0] rx_d;
  reg        transfer_done_flag_d;

  wire       acc;
  wire       wr_ctrl;
  wire       wr_data;
  wire       wr_stat;
  wire       wr_aux;
  wire       rd_stat;
  wire       data_acc;
  wire       mapped;
  wire       en;
  wire       is_master;
  wire       lsb_first;
  wire       clock_idle_level;
  wire       clock_sample_phase;
  wire       select_pin_enable;
  wire       ss_dir_out;
  wire       ss_eff;
  wire       ss_is_input;
  wire       mode_fault;
  wire       slave_act;
  wire       slave_drop;
  wire       busy;
  wire [6:0] half;
  wire       tick;
  wire       sck_rise;
  wire       sck_fall;
  wire       lead;
  wire       trail;
  wire       sample;
  wire       setup;
  wire       din;
  wire       done;
  wire       tx_bit;
  wire       transfer_done_flag_clr;
  wire       write_collision_flag_clr;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stage feeds only the second.

  // Pins from the link pass two flops; a third stage finds edges.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_s1_q  <= 1'b0;
      sck_s2_q  <= 1'b0;
      sck_s3_q  <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      ss_s1_q   <= 1'b1;
      ss_s2_q   <= 1'b1;
      ss_s3_q   <= 1'b1;
    end
    else
    begin
      sck_s1_q  <= sck_i;
      sck_s2_q  <= sck_s1_q;
      sck_s3_q  <= sck_s2_q;
      mosi_s1_q <= mosi_i;
      mosi_s2_q <= mosi_s1_q;
      miso_s1_q <= miso_i;
      miso_s2_q <= miso_s1_q;
      ss_s1_q   <= ss_n_i;
      ss_s2_q   <= ss_s1_q;
      ss_s3_q   <= ss_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A transfer takes effect in the access cycle in which pready is high.
  assign acc      = psel & penable & pready;
  assign mapped   = hit(paddr, `SMSP_IDX_CTRL) | hit(paddr, `SMSP_IDX_DATA) |
                    hit(paddr, `SMSP_IDX_STAT) | hit(paddr, `SMSP_IDX_AUX);
  assign wr_ctrl  = acc & pwrite & hit(paddr, `SMSP_IDX_CTRL);
  assign wr_data  = acc & pwrite & hit(paddr, `SMSP_IDX_DATA);
  assign wr_stat  = acc & pwrite & hit(paddr, `SMSP_IDX_STAT);
  assign wr_aux   = acc & pwrite & hit(paddr, `SMSP_IDX_AUX);
  assign rd_stat  = acc & ~pwrite & hit(paddr, `SMSP_IDX_STAT);
  assign data_acc = acc & hit(paddr, `SMSP_IDX_DATA);

  //////////////////////////////////////////////////////////////////////////////
  // Mode and select decoding.

  // Control fields and the effective select level.
  assign en          = ctrl_q[`SMSP_CR_EN];
  assign is_master   = ctrl_q[`SMSP_CR_MS];
  assign lsb_first   = ctrl_q[`SMSP_CR_LSB];
  assign clock_idle_level        = ctrl_q[`SMSP_CR_CLOCK_IDLE_LEVEL];
  assign clock_sample_phase        = ctrl_q[`SMSP_CR_CLOCK_SAMPLE_PHASE];
  assign select_pin_enable       = stat_q[`SMSP_SR_SELECT_PIN_ENABLE];
  assign ss_dir_out  = aux_q[`SMSP_AX_SSDIR];
  assign ss_eff      = select_pin_enable ? ss_s2_q : is_master;
  assign ss_is_input = select_pin_enable & (~is_master | ~ss_dir_out);
  assign mode_fault  = en & is_master & select_pin_enable & ~ss_dir_out & ~ss_s2_q;
  assign slave_act   = en & ~is_master & ~ss_eff;
  assign slave_drop  = en & ~is_master & ss_eff;
  assign busy        = run_q | (bit_cnt_q != 4'h0);

  //////////////////////////////////////////////////////////////////////////////
  // Clock edge events.

  // Master edges come from the divider, slave edges from the synced SCK.
  assign half     = half_period(ctrl_q[`SMSP_CR_DBL],
                                ctrl_q[`SMSP_CR_RATE_HI:`SMSP_CR_RATE_LO]);
  assign tick     = run_q & (div_cnt_q == (half - 7'h01));
  assign sck_rise = sck_s2_q & ~sck_s3_q;
  assign sck_fall = ~sck_s2_q & sck_s3_q;
  assign lead     = is_master ? (tick & ~edge_cnt_q[0])
                              : (slave_act & (clock_idle_level ? sck_fall : sck_rise));
  assign trail    = is_master ? (tick & edge_cnt_q[0])
                              : (slave_act & (clock_idle_level ? sck_rise : sck_fall));
  assign sample   = clock_sample_phase ? trail : lead;
  assign setup    = clock_sample_phase ? lead : trail;
  assign din      = stat_q[`SMSP_SR_RECEIVE_ENABLE] &
                    (is_master ? miso_s2_q : mosi_s2_q);
  assign done     = is_master ? (tick & (edge_cnt_q == `SMSP_LAST_EDGE))
                              : (sample & (bit_cnt_q == `SMSP_LAST_BIT));
  assign tx_bit   = lsb_first ? tx_q[0] : tx_q[7];

  // Next receive shift value, with the sampled bit entering per bit order.
  always @*
  begin
    rx_d = rx_q;
    if (sample)
    begin
      if (lsb_first)
        rx_d = {din, rx_q[7:1]};
      else
        rx_d = {rx_q[6:0], din};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift engine.

  // Runs one exchange; select loss, mode fault or disable abort it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q      <= 1'b0;
      sck_q      <= 1'b0;
      bit_cnt_q  <= 4'h0;
      edge_cnt_q <= 5'h00;
      div_cnt_q  <= 7'h00;
      tx_q       <= `SMSP_RST_BYTE;
      rx_q       <= `SMSP_RST_BYTE;
      rxbuf_q    <= `SMSP_RST_BYTE;
    end
    else if (!en || slave_drop || mode_fault)
    begin
      run_q      <= 1'b0;
      sck_q      <= clock_idle_level;
      bit_cnt_q  <= 4'h0;
      edge_cnt_q <= 5'h00;
      div_cnt_q  <= 7'h00;
      rx_q       <= `SMSP_RST_BYTE;
      if (wr_data && !busy)
        tx_q <= pwdata[7:0];
    end
    else if (wr_data && !busy)
    begin
      tx_q       <= pwdata[7:0];
      run_q      <= is_master;
      sck_q      <= clock_idle_level;
      bit_cnt_q  <= 4'h0;
      edge_cnt_q <= 5'h00;
      div_cnt_q  <= 7'h00;
    end
    else
    begin
      if (tick)
      begin
        sck_q      <= ~sck_q;
        edge_cnt_q <= edge_cnt_q + 5'h01;
        div_cnt_q  <= 7'h00;
      end
      else if (run_q)
        div_cnt_q <= div_cnt_q + 7'h01;
      if (!run_q)
        sck_q <= clock_idle_level;
      rx_q <= rx_d;
      if (sample)
        bit_cnt_q <= bit_cnt_q + 4'h1;
      // The first bit is already on the line, so shifting waits for a sample.
      if (setup && (bit_cnt_q != 4'h0))
      begin
        if (lsb_first)
          tx_q <= {1'b0, tx_q[7:1]};
        else
          tx_q <= {tx_q[6:0], 1'b0};
      end
      if (done)
      begin
        run_q     <= 1'b0;
        sck_q     <= clock_idle_level;
        bit_cnt_q <= 4'h0;
        rxbuf_q   <= rx_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers and flags.

  // Status read arms the clear; the next data access clears the collision flag, and the done flag while interrupts are off.
  assign transfer_done_flag_clr = (data_acc & arm_q & ~aux_q[`SMSP_AX_IE]) |
                    (irq_ack & aux_q[`SMSP_AX_IE]);
  assign write_collision_flag_clr = data_acc & arm_q;

  // Next done flag; a setting event wins over a clear.
  always @*
  begin
    transfer_done_flag_d = done | mode_fault | (stat_q[`SMSP_SR_DONE] & ~transfer_done_flag_clr);
  end

  // Software registers; hardware flags are set over any clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `SMSP_RST_BYTE;
      stat_q <= `SMSP_RST_BYTE;
      aux_q  <= `SMSP_RST_BYTE;
      arm_q  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= pwdata[7:0];
      if (mode_fault)
        ctrl_q[`SMSP_CR_MS] <= 1'b0;
      if (wr_aux)
        aux_q <= pwdata[7:0] & `SMSP_AX_WMASK;
      if (wr_stat)
        stat_q[3:0] <= pwdata[3:0];
      stat_q[`SMSP_SR_DONE] <= transfer_done_flag_d;
      stat_q[`SMSP_SR_WRITE_COLLISION_FLAG] <= (wr_data & busy) |
                               (stat_q[`SMSP_SR_WRITE_COLLISION_FLAG] & ~write_collision_flag_clr);
      stat_q[`SMSP_SR_SSRISE] <= (ss_is_input & ss_s2_q & ~ss_s3_q) |
                                 (stat_q[`SMSP_SR_SSRISE] &
                                  ~(wr_stat & ~pwdata[`SMSP_SR_SSRISE]));
      stat_q[4] <= 1'b0;
      if (rd_stat)
        arm_q <= 1'b1;
      else if (data_acc)
        arm_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  // One wait state: pready rises in the second access cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite)
      begin
        if (hit(paddr, `SMSP_IDX_CTRL))
          prdata <= {24'h000000, ctrl_q};
        else if (hit(paddr, `SMSP_IDX_DATA))
          prdata <= {24'h000000, rxbuf_q};
        else if (hit(paddr, `SMSP_IDX_STAT))
          prdata <= {24'h000000, stat_q};
        else if (hit(paddr, `SMSP_IDX_AUX))
          prdata <= {24'h000000, aux_q};
        else
          prdata <= 32'h00000000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and interrupt outputs.

  // Every pin output is registered; enables are low while driving.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_o     <= 1'b0;
      sck_oe_n  <= 1'b1;
      mosi_o    <= 1'b0;
      mosi_oe_n <= 1'b1;
      miso_o    <= 1'b0;
      miso_oe_n <= 1'b1;
      ss_n_o    <= 1'b1;
      ss_n_oe_n <= 1'b1;
      irq       <= 1'b0;
    end
    else
    begin
      sck_o     <= sck_q;
      sck_oe_n  <= ~(en & is_master);
      mosi_o    <= tx_bit;
      mosi_oe_n <= ~(en & is_master & stat_q[`SMSP_SR_TRANSMIT_ENABLE]);
      miso_o    <= tx_bit;
      miso_oe_n <= ~(slave_act & stat_q[`SMSP_SR_TRANSMIT_ENABLE]);
      ss_n_o    <= aux_q[`SMSP_AX_SSOUT];
      ss_n_oe_n <= ~(is_master & select_pin_enable & ss_dir_out);
      irq       <= transfer_done_flag_d & aux_q[`SMSP_AX_IE];
    end
  end

endmodule // smsp_core

/* File: dv/smsp_slave_model.sv */
`timescale 1ns/1ns
module smsp_slave_model (
  input  wire       sck,
  input  wire       mosi,
  input  wire       ss_n,
  input  wire [7:0] tx_byte,
  output reg        miso,
  output reg  [7:0] rx_byte
);
  reg [7:0] sh_q;

  // Released line starts high; each select loads the reply byte.
  initial miso = 1'b1;
  always @(negedge ss_n)
  begin
    sh_q = tx_byte;
    miso = tx_byte[7];
  end

  // Mode zero, MSB first: sample on rise, set up the next bit on fall.
  always @(posedge sck)
    if (!ss_n)
      rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck)
    if (!ss_n)
    begin
      sh_q = {sh_q[6:0], 1'b0};
      miso = sh_q[7];
    end

  // Deselected, the line shows the inverse of its last bit, never a held value.
  always @(posedge ss_n)
    miso = ~miso;
endmodule // smsp_slave_model

/* File: dv/smsp_core_checker.sv */
`timescale 1ns/1ns
`include "smsp_defines.vh"
module smsp_core_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sck_o,
  input wire        sck_oe_n,
  input wire        mosi_oe_n,
  input wire        miso_oe_n,
  input wire        ss_n_o,
  input wire        ss_n_oe_n
);
  reg  [7:0] ctrl_q;
  reg  [7:0] aux_q;
  wire       wr_ok;
  wire       mapped;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow copies of control and auxiliary writes seen on the bus.
  assign wr_ok  = psel && penable && pready && pwrite && !pslverr;
  assign mapped = paddr[11:2] >= `SMSP_IDX_CTRL && paddr[11:2] <= `SMSP_IDX_AUX;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_q <= 8'h00;
      aux_q  <= 8'h00;
    end
    else if (wr_ok && paddr[11:2] == `SMSP_IDX_CTRL)
      ctrl_q <= pwdata[7:0];
    else if (wr_ok && paddr[11:2] == `SMSP_IDX_AUX)
      aux_q <= pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_aux_steady; $stable(aux_q) [*3]; endsequence

  property p_one_wait; s_setup ##1 s_access |-> !pready ##1 (pready && psel && penable);
  endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_slverr; pready |-> pslverr == !mapped; endproperty
  property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
  property p_unmapped_zero; pready && pslverr && !pwrite |-> prdata == 32'h00000000;
  endproperty
  property p_sck_half;
    !sck_oe_n && ctrl_q[2:0] == 3'b001 && $changed(sck_o) |=> $stable(sck_o) [*7];
  endproperty
  property p_mosi_master; !mosi_oe_n |-> !sck_oe_n; endproperty
  property p_miso_slave; !miso_oe_n |-> sck_oe_n; endproperty
  property p_ss_level; s_aux_steady ##0 !ss_n_oe_n |-> ss_n_o == aux_q[2]; endproperty
  property p_ss_input; sck_oe_n |-> ss_n_oe_n; endproperty

  a_one_wait: assert property (p_one_wait)
    else $error("ready did not follow one wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  a_slverr: assert property (p_slverr)
    else $error("error response does not match the address map");
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned data");
  a_sck_half: assert property (p_sck_half)
    else $error("clock half period shorter than eight cycles");
  a_mosi_master: assert property (p_mosi_master)
    else $error("data out driven while not master");
  a_miso_slave: assert property (p_miso_slave)
    else $error("data back driven while master");
  a_ss_level: assert property (p_ss_level)
    else $error("select output differs from its software level");
  a_ss_input: assert property (p_ss_input)
    else $error("select driven outside master mode");
endmodule // smsp_core_checker

bind smsp_core smsp_core_checker smsp_core_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
  .ss_n_o(ss_n_o), .ss_n_oe_n(ss_n_oe_n));

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`include "smsp_defines.vh"
module tb_top;
  localparam logic [11:0] A_CTRL = {`SMSP_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_DATA = {`SMSP_IDX_DATA, 2'b00};
  localparam logic [11:0] A_STAT = {`SMSP_IDX_STAT, 2'b00};
  localparam logic [11:0] A_AUX  = {`SMSP_IDX_AUX, 2'b00};
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  tx_m;
  logic        ss_drv;
  logic        irq_ack_drv;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  wire         sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_n_oe_n;
  wire         miso_m;
  wire  [7:0]  rx_m;
  int          num_errors;
  int          check_count;

  // Pin levels from every party; select has a pull-up held by the bench.
  wire sck_w  = sck_oe_n ? 1'b0 : sck_o;
  wire mosi_w = mosi_oe_n ? 1'b1 : mosi_o;
  wire miso_w = miso_oe_n ? miso_m : miso_o;
  wire ss_w   = ss_n_oe_n ? ss_drv : ss_n_o;

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  smsp_core smsp_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_ack(irq_ack_drv), .irq(irq), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
    .ss_n_oe_n(ss_n_oe_n));
  smsp_slave_model smsp_slave_model_inst (
    .sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .tx_byte(tx_m), .miso(miso_m), .rx_byte(rx_m));

  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer: setup, access until ready, then release.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_sim;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk(what, r, {24'h000000, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset_values;
    rd_chk(A_CTRL, 8'h00, "control reset");
    rd_chk(A_DATA, 8'h00, "data reset");
    rd_chk(A_STAT, 8'h00, "status reset");
  endtask

  task t_unmapped;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h004, 8'h00, r, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask

  // Master exchange with a collision write; done and collision clear together.
  task automatic t_exchange(input logic [7:0] cr, input logic [7:0] mo, input logic [7:0] so,
                            input logic [7:0] exp_slave, input logic [7:0] exp_master);
    logic [31:0] r;
    logic        e;
    int          n;
    tx_m <= so;
    wr(A_STAT, 8'h07);
    wr(A_AUX, 8'h06);
    wr(A_CTRL, cr);
    wr(A_AUX, 8'h02);
    wr(A_DATA, mo);
    wr(A_DATA, 8'hFF);
    n = 0;
    do
    begin
      apb(1'b0, A_STAT, 8'h00, r, e);
      n++;
    end
    while (r[7] !== 1'b1 && n < 100);
    chk("status done", r, 32'hC7);
    if (r[7] !== 1'b1)
      end_sim;
    chk("clock idle", {31'h0, sck_o}, 32'h0);
    rd_chk(A_DATA, exp_master, "received byte");
    chk("slave received", {24'h0, rx_m}, {24'h0, exp_slave});
    rd_chk(A_STAT, 8'h07, "flags cleared");
    wr(A_AUX, 8'h06);
  endtask

  // Select driven low as input while master: fall back to slave.
  task t_mode_fault;
    ss_drv <= 1'b0;
    wr(A_AUX, 8'h00);
    repeat (4) @(posedge pclk);
    rd_chk(A_CTRL, 8'hC1, "control after fault");
    rd_chk(A_STAT, 8'h87, "status after fault");
    ss_drv <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(A_STAT, 8'hA7, "select rise");
    wr(A_STAT, 8'h07);
    rd_chk(A_STAT, 8'h87, "select rise cleared");
  endtask

  // Interrupt enabled with the done flag pending; a service pulse clears both.
  task t_irq_service;
    wr(A_AUX, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    irq_ack_drv <= 1'b1;
    @(posedge pclk);
    irq_ack_drv <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk(A_STAT, 8'h07, "done cleared by service");
    wr(A_AUX, 8'h00);
  endtask

  initial
  begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h00000000;
    tx_m        = 8'h00;
    ss_drv      = 1'b1;
    irq_ack_drv = 1'b0;
    num_errors  = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    t_unmapped;
    // Rate one gives eight-cycle halves, enough for the three-cycle pin round trip.
    t_exchange(8'hA1, 8'hC4, 8'h1E, 8'hC4, 8'h1E);
    t_exchange(8'hE1, 8'hC4, 8'h1E, 8'h23, 8'h78);
    t_mode_fault;
    t_irq_service;
    end_sim;
  end
endmodule // tb_top
